// [dv/bsad_mem_model.sv]
// storage stand-in behind the shared buffer space decoder
// assumes read strobe and address arrive combinationally from the decoder
`timescale 1ns/1ps
module bsad_mem_model (
    input  wire logic        clock_i,
    input  wire logic        re_i,
    input  wire logic [15:0] addr_i,
    output logic      [7:0]  rdata_o
);
    logic [7:0] last_q = 8'h00;
    always @(posedge clock_i) begin
        if (re_i) begin
            last_q <= addr_i[7:0] ^ 8'h5A;
        end
    end
    // released bus shows the inverse of the last value
    assign rdata_o = re_i ? (addr_i[7:0] ^ 8'h5A) : ~last_q;
endmodule : bsad_mem_model

// [dv/buffer_space_access_decoder_tb.sv]
// self-checking bench for the shared buffer space access decoder
// assumes the decoder and the storage model compile before it
`timescale 1ns/1ps
module buffer_space_access_decoder_tb;
    import bsad_pkg::*;
    typedef struct packed {
        bsad_master_e m;
        logic         du;
        logic         we;
        logic [15:0]  a;
        logic         g;
        logic         d;
    } bsad_row_s;
    logic         clock_i, arst_n_i, clk_en_i, req_i, we_i, desc_update_i, boot_mode_i;
    bsad_master_e master_i;
    logic [15:0]  addr_i;
    logic [7:0]   mem_rdata_i, rdata_o;
    logic         in_region_o, mem_we_o, mem_re_o, granted_o, denied_o;
    int           fails = 0;
    int           tests_run = 0;
    bsad_row_s    r;
    bsad_row_s    rows [19] = '{
        '{BSAD_CORE, 0, 0, 16'hF800, 1, 0}, '{BSAD_DMA, 0, 1, 16'hFEEF, 1, 0},
        '{BSAD_ENGINE, 0, 0, 16'hFEF0, 1, 0}, '{BSAD_DMA, 0, 0, 16'hFF00, 0, 1},
        '{BSAD_ENGINE, 0, 1, 16'hFF07, 1, 0}, '{BSAD_DMA, 0, 0, 16'hFF08, 0, 1},
        '{BSAD_DMA, 1, 0, 16'hFF08, 1, 0}, '{BSAD_ENGINE, 1, 0, 16'hFF5F, 1, 0},
        '{BSAD_CORE, 0, 0, 16'hFF1B, 0, 0}, '{BSAD_CORE, 0, 0, 16'hFF60, 0, 0},
        '{BSAD_ENGINE, 0, 0, 16'hFF83, 1, 0}, '{BSAD_ENGINE, 0, 0, 16'hFF84, 0, 1},
        '{BSAD_DMA, 0, 1, 16'hFFA0, 1, 0}, '{BSAD_DMA, 0, 0, 16'hFF90, 0, 1},
        '{BSAD_CORE, 0, 1, 16'hFFFF, 1, 0}, '{BSAD_CORE, 0, 0, 16'hFF85, 0, 0},
        '{BSAD_CORE, 0, 1, 16'hFFF5, 0, 0}, '{BSAD_CORE, 0, 1, 16'hFF0D, 1, 0},
        '{BSAD_CORE, 0, 0, 16'hF7FF, 0, 1}};

    bsad_decoder bsad_decoder_i (.clock_i, .arst_n_i, .clk_en_i, .req_i, .we_i, .master_i,
        .desc_update_i, .boot_mode_i, .addr_i, .mem_rdata_i, .in_region_o, .mem_we_o,
        .mem_re_o, .rdata_o, .granted_o, .denied_o);
    bsad_mem_model bsad_mem_model_i (.clock_i, .re_i(mem_re_o), .addr_i,
        .rdata_o(mem_rdata_i));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s exp %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    initial begin
        arst_n_i = 0; clk_en_i = 1; req_i = 0; we_i = 0; master_i = BSAD_CORE;
        desc_update_i = 0; boot_mode_i = 0; addr_i = 16'hF800;
        repeat (20) @(negedge clock_i);
        check("reset grant", granted_o, 0);
        arst_n_i = 1;
        // whole map twice, once per mode strap, requests back to back
        for (int b = 0; b < 2; b++) begin
            boot_mode_i = b[0];
            for (int i = 0; i < 19; i++) begin
                r = rows[i];
                req_i = 1; we_i = r.we; master_i = r.m; desc_update_i = r.du; addr_i = r.a;
                #1;
                check("region", in_region_o, r.a >= 16'hF800);
                check("write strobe", mem_we_o, r.g & r.we);
                check("read strobe", mem_re_o, r.g & ~r.we);
                @(negedge clock_i);
                check("granted", granted_o, r.g);
                check("denied", denied_o, r.d);
                check("rdata", rdata_o, (r.g & ~r.we) ? r.a[7:0] ^ 8'h5A : 8'h00);
            end
        end
        // clock enable low blocks strobes and freezes the registered outputs
        clk_en_i = 0; master_i = BSAD_CORE; we_i = 0; addr_i = 16'hF800;
        #1;
        check("frozen strobe", mem_re_o, 0);
        @(negedge clock_i);
        check("frozen deny", denied_o, 1);
        clk_en_i = 1;
        @(negedge clock_i);
        check("enabled grant", granted_o, 1);
        arst_n_i = 0;
        #1;
        check("mid reset grant", granted_o, 0);
        check("mid reset rdata", rdata_o, 0);
        summarize();
    end
endmodule : buffer_space_access_decoder_tb

// [hdl/bsad_decoder.sv]
// access decoder for the top 2 KB shared data space
// assumes one request per cycle, synchronous to clock_i
`timescale 1ns/1ps
`include "bsad_params.svh"
// How it works
// RQ1 - addresses F800h to FFFFh form the shared region.
// RQ2 - FF80h-FFFFh are mapped registers; core reaches all but the reserved holes.
// RQ3 - engine reaches only ep0 registers; dma also its data register.
// RQ4 - descriptor range: core always, engine and dma only for descriptor updates.
// RQ5 - setup block core and engine only; ep0 buffers all masters.
// RQ6 - F800h to FEEFh buffer space open to all three masters.
// RQ7 - six 8-byte descriptor blocks; bytes 3 and 4 spare.
// RQ8 - ep0 registers at FF80h to FF83h.
// RQ9 - region map does not depend on boot or normal mode.
// RQ10 - forbidden access: write blocked, read returns zero.
// RQ11 - reserved register and descriptor addresses read zero, writes ignored.
module bsad_decoder (
    input  wire logic                  clock_i,
    input  wire logic                  arst_n_i,
    input  wire logic                  clk_en_i,
    input  wire logic                  req_i,
    input  wire logic                  we_i,
    input  wire bsad_pkg::bsad_master_e master_i,
    input  wire logic                  desc_update_i,
    input  wire logic                  boot_mode_i,
    input  wire logic [15:0]           addr_i,
    input  wire logic [7:0]            mem_rdata_i,
    output logic                       in_region_o,
    output logic                       mem_we_o,
    output logic                       mem_re_o,
    output logic [7:0]                 rdata_o,
    output logic                       granted_o,
    output logic                       denied_o
);
    import bsad_pkg::*;

    // reserved holes of the mapped register range, lowest and highest address
    localparam int          NSPARE = 8;
    localparam logic [15:0] SPARE_LO [NSPARE] = '{
        `BSAD_MREG_HOLE0_LO,
        `BSAD_MREG_HOLE1_LO,
        `BSAD_MREG_HOLE2_LO,
        `BSAD_MREG_HOLE3_LO,
        `BSAD_MREG_HOLE4_LO,
        `BSAD_MREG_HOLE5_LO,
        `BSAD_MREG_HOLE6_LO,
        `BSAD_MREG_HOLE7_LO
    };
    localparam logic [15:0] SPARE_HI [NSPARE] = '{
        `BSAD_MREG_HOLE0_HI,
        `BSAD_MREG_HOLE1_HI,
        `BSAD_MREG_HOLE2_HI,
        `BSAD_MREG_HOLE3_HI,
        `BSAD_MREG_HOLE4_HI,
        `BSAD_MREG_HOLE5_HI,
        `BSAD_MREG_HOLE6_HI,
        `BSAD_MREG_HOLE7_HI
    };

    bsad_state_s s_q;
    bsad_state_s s_d;
    logic [5:0]  desc_hit;
    logic [5:0]  desc_spare;
    logic        in_reg;
    logic        in_desc;
    logic        in_setup;
    logic        in_ep0buf;
    logic        in_buf;
    logic        is_ep0_reg;
    logic        reserved;
    logic        desc_hole;
    logic [NSPARE-1:0] reg_hole;
    logic        allow;
    logic        go;

    genvar g;
    generate
        for (g = 0; g < 2 * `BSAD_DESC_EPS; g++) begin : g_desc
            localparam logic [15:0] B = (g < `BSAD_DESC_EPS)
                ? 16'(`BSAD_OUT_DESC1 + 16'(g * 8))
                : 16'(`BSAD_IN_DESC1 + 16'((g - `BSAD_DESC_EPS) * 8));
            bsad_desc_chk #(.BASE(B)) u_chk (
                .addr_i  (addr_i),
                .hit_o   (desc_hit[g]),
                .spare_o (desc_spare[g])
            );
        end
    endgenerate

    generate
        for (genvar k = 0; k < NSPARE; k++) begin : g_hole
            assign reg_hole[k] = (addr_i >= SPARE_LO[k]) && (addr_i <= SPARE_HI[k]); // [RQ11]
        end
    endgenerate

    // decoding ignores boot_mode_i on purpose
    assign in_region_o = (addr_i >= `BSAD_REGION_BASE); // [RQ1] [RQ9]
    assign in_reg      = (addr_i >= `BSAD_MREG_BASE); // [RQ2]
    assign in_desc     = (addr_i >= `BSAD_DESC_BASE) && (addr_i <= `BSAD_DESC_TOP); // [RQ4]
    assign in_setup    = (addr_i >= `BSAD_SETUP_BASE) && (addr_i <= `BSAD_SETUP_TOP); // [RQ5]
    assign in_ep0buf   = (addr_i >= `BSAD_OUT_EP0_BASE) && (addr_i < `BSAD_SETUP_BASE); // [RQ5]
    assign in_buf      = in_region_o && (addr_i <= `BSAD_BUF_TOP); // [RQ6]
    assign is_ep0_reg  = (addr_i >= `BSAD_IN_EP0_CFG) && (addr_i <= `BSAD_OUT_EP0_CNT); // [RQ8]
    // reserved descriptor space: outside any block, or a spare byte
    assign desc_hole   = in_desc && (~|desc_hit || |desc_spare); // [RQ11]
    assign reserved    = desc_hole || |reg_hole; // [RQ11]

    always_comb begin
        allow = 1'b0;
        if (in_buf || in_ep0buf) begin
            allow = 1'b1; // [RQ5] [RQ6]
        end else if (in_setup) begin
            allow = (master_i != BSAD_DMA); // [RQ5]
        end else if (in_desc) begin
            allow = (master_i == BSAD_CORE) || desc_update_i; // [RQ4]
        end else if (in_reg) begin
            case (master_i)
                BSAD_CORE:   allow = 1'b1; // [RQ2]
                BSAD_ENGINE: allow = is_ep0_reg; // [RQ3]
                BSAD_DMA:    allow = is_ep0_reg || addr_i == `BSAD_DMA_DATA_REG; // [RQ3]
                default:     allow = 1'b0;
            endcase
        end
    end

    assign go       = req_i && clk_en_i;
    assign mem_we_o = go && we_i && allow && !reserved; // [RQ10] [RQ11]
    assign mem_re_o = go && !we_i && allow && !reserved;

    always_comb begin
        s_d = s_q;
        if (go) begin
            s_d.granted = allow && !reserved;
            s_d.denied  = !allow;
            s_d.rdata   = (!we_i && allow && !reserved) ? mem_rdata_i : 8'h00; // [RQ10] [RQ11]
            if (!in_region_o) begin
                s_d.st = BSAD_ST_MISS;
            end else if (allow && !reserved) begin
                s_d.st = BSAD_ST_OK;
            end else begin
                s_d.st = BSAD_ST_DENY;
            end
        end else if (clk_en_i) begin
            s_d.granted = 1'b0;
            s_d.denied  = 1'b0;
            case (s_q.st)
                BSAD_ST_IDLE: s_d.st = BSAD_ST_IDLE;
                BSAD_ST_OK:   s_d.st = BSAD_ST_IDLE;
                BSAD_ST_DENY: s_d.st = BSAD_ST_IDLE;
                BSAD_ST_MISS: s_d.st = BSAD_ST_IDLE;
                default:      s_d.st = BSAD_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q <= '{st: BSAD_ST_IDLE, rdata: 8'h00, granted: 1'b0, denied: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_o   = s_q.rdata;
    assign granted_o = s_q.granted;
    assign denied_o  = s_q.denied;

    a_dma_setup_deny: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [RQ5]
        (req_i && clk_en_i && master_i == BSAD_DMA && in_setup) |=> denied_o && rdata_o == 8'h00)
        else $error("dma reached setup block");
    a_core_reg_ok: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [RQ2]
        (go && master_i == BSAD_CORE && in_reg && !reserved) |=> granted_o)
        else $error("core refused in register range");
    a_engine_reg_only: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [RQ3]
        ((mem_we_o || mem_re_o) && master_i == BSAD_ENGINE && in_reg) |-> addr_i <= 16'hFF83)
        else $error("engine wrote non ep0 register");
    a_desc_update: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [RQ4]
        (go && master_i != BSAD_CORE && in_desc && !desc_update_i) |-> !mem_we_o && !mem_re_o)
        else $error("descriptor touched without update");
    a_buf_open: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [RQ6]
        (go && addr_i >= 16'hF800 && addr_i <= 16'hFEEF) |=> granted_o)
        else $error("buffer access refused");
    a_spare_zero: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [RQ11]
        (go && !we_i && in_desc && addr_i[2:0] == 3'h3) |=> rdata_o == 8'h00 && !granted_o)
        else $error("spare byte not zero");
    a_deny_no_write: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [RQ10]
        denied_o |-> !$past(mem_we_o))
        else $error("denied access wrote");
    a_grant_pulse: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [RQ1]
        (go && addr_i < 16'hF800) |=> !granted_o ##1 (!granted_o || $past(go)))
        else $error("outside region granted");

    // one check per permitted or refused range, and one for the reserved register holes
    a_reg_hole_zero: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [RQ11]
        (go && |reg_hole) |-> (!mem_we_o && !mem_re_o) ##1 (!granted_o && rdata_o == 8'h00))
        else $error("reserved register reached");
    a_ep0buf_open: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [RQ5]
        (go && in_ep0buf) |=> granted_o)
        else $error("ep0 buffer refused");
    a_setup_open: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [RQ5]
        (go && in_setup && master_i != BSAD_DMA) |=> granted_o)
        else $error("setup block refused");
    a_desc_core: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [RQ4]
        (go && master_i == BSAD_CORE && in_desc && !reserved) |=> granted_o)
        else $error("core refused in descriptor range");
    a_ep0_reg_open: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [RQ8]
        (go && is_ep0_reg) |=> granted_o)
        else $error("ep0 register refused");
    a_dma_data_reg: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [RQ3]
        (go && master_i == BSAD_DMA && addr_i == `BSAD_DMA_DATA_REG) |=> granted_o)
        else $error("dma data register refused");
    a_dma_reg_only: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [RQ3]
        (go && master_i == BSAD_DMA && in_reg && !is_ep0_reg
            && addr_i != `BSAD_DMA_DATA_REG) |-> !mem_we_o && !mem_re_o)
        else $error("dma reached other register");
    a_engine_reg_deny: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [RQ3]
        (go && master_i == BSAD_ENGINE && in_reg && !is_ep0_reg) |=> denied_o)
        else $error("engine not refused in register range");
    a_refused_zero: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [RQ10]
        (go && !allow) |-> (!mem_we_o && !mem_re_o) ##1 (denied_o && rdata_o == 8'h00))
        else $error("refused access not blocked");
endmodule : bsad_decoder

// [hdl/bsad_desc_chk.sv]
// checks one 8-byte endpoint descriptor block
// assumes a 16-bit address from the same clock domain
`timescale 1ns/1ps
`include "bsad_params.svh"
module bsad_desc_chk #(
    parameter logic [15:0] BASE = 16'hFF08
) (
    input  wire logic [15:0] addr_i,
    output logic             hit_o,
    output logic             spare_o
);
    // block covers base to base+7; bytes 3 and 4 unused
    assign hit_o   = (addr_i[15:3] == BASE[15:3]); // [RQ7]
    assign spare_o = hit_o && (addr_i[2:0] == `BSAD_DESC_SPARE_LO
                              || addr_i[2:0] == `BSAD_DESC_SPARE_HI); // [RQ7]
endmodule : bsad_desc_chk

// [hdl/bsad_params.svh]
// constants for the shared buffer space access decoder
// assumes a 16-bit data-space address from each master
`ifndef BSAD_PARAMS_SVH
`define BSAD_PARAMS_SVH
`define BSAD_REGION_BASE     16'hF800
`define BSAD_REGION_TOP      16'hFFFF
`define BSAD_BUF_TOP         16'hFEEF
`define BSAD_OUT_EP0_BASE    16'hFEF0
`define BSAD_IN_EP0_BASE     16'hFEF8
`define BSAD_SETUP_BASE      16'hFF00
`define BSAD_SETUP_TOP       16'hFF07
`define BSAD_DESC_BASE       16'hFF08
`define BSAD_DESC_TOP        16'hFF7F
`define BSAD_MREG_BASE       16'hFF80
`define BSAD_IN_EP0_CFG      16'hFF80
`define BSAD_IN_EP0_CNT      16'hFF81
`define BSAD_OUT_EP0_CFG     16'hFF82
`define BSAD_OUT_EP0_CNT     16'hFF83
`define BSAD_OUT_DESC1       16'hFF08
`define BSAD_IN_DESC1        16'hFF48
`define BSAD_DESC_EPS        3
`define BSAD_DESC_SPARE_LO   3'h3
`define BSAD_DESC_SPARE_HI   3'h4
`define BSAD_DMA_DATA_REG    16'hFFA0
`define BSAD_MREG_HOLE0_LO   16'hFF84
`define BSAD_MREG_HOLE0_HI   16'hFF8F
`define BSAD_MREG_HOLE1_LO   16'hFF91
`define BSAD_MREG_HOLE1_HI   16'hFF91
`define BSAD_MREG_HOLE2_LO   16'hFF94
`define BSAD_MREG_HOLE2_HI   16'hFF9D
`define BSAD_MREG_HOLE3_LO   16'hFF9F
`define BSAD_MREG_HOLE3_HI   16'hFF9F
`define BSAD_MREG_HOLE4_LO   16'hFFAC
`define BSAD_MREG_HOLE4_HI   16'hFFDF
`define BSAD_MREG_HOLE5_LO   16'hFFE2
`define BSAD_MREG_HOLE5_HI   16'hFFE3
`define BSAD_MREG_HOLE6_LO   16'hFFE6
`define BSAD_MREG_HOLE6_HI   16'hFFE7
`define BSAD_MREG_HOLE7_LO   16'hFFF4
`define BSAD_MREG_HOLE7_HI   16'hFFFA
`endif

// [hdl/bsad_pkg.sv]
// types for the shared buffer space access decoder
// assumes nothing beyond the params header
package bsad_pkg;
    typedef enum logic [2:0] {
        BSAD_CORE   = 3'b001,
        BSAD_DMA    = 3'b010,
        BSAD_ENGINE = 3'b100
    } bsad_master_e;
    typedef enum logic [3:0] {
        BSAD_ST_IDLE = 4'b0001,
        BSAD_ST_OK   = 4'b0010,
        BSAD_ST_DENY = 4'b0100,
        BSAD_ST_MISS = 4'b1000
    } bsad_state_e;
    typedef struct packed {
        bsad_state_e st;
        logic [7:0]  rdata;
        logic        granted;
        logic        denied;
    } bsad_state_s;
endpackage : bsad_pkg
